// ### pkg/anps_pkg.sv
// package for the negotiation result and setup register bank
// assumes a 125 MHz core clock and a 5-bit register address from the mii side
package anps_pkg;
  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam logic [4:0] ANPS_ADDR_PARTNER_ABILITY = 5'h05;
  localparam logic [4:0] ANPS_ADDR_NEGOTIATION_EXPANSION = 5'h06;
  localparam logic [4:0] ANPS_ADDR_NEGOTIATION_SETUP = 5'h10;

  // ------------------------------------------------------------
  // partner ability field positions
  // ------------------------------------------------------------
  localparam int ANPS_PA_NEXT_PAGE = 15;
  localparam int ANPS_PA_ACK = 14;
  localparam int ANPS_PA_REMOTE_FAULT = 13;
  localparam int ANPS_PA_PAUSE = 10;
  localparam int ANPS_PA_FOUR_PAIR = 9;
  localparam int ANPS_PA_FAST_FD = 8;
  localparam int ANPS_PA_FAST_HD = 7;
  localparam int ANPS_PA_SLOW_FD = 6;
  localparam int ANPS_PA_SLOW_HD = 5;
  localparam int ANPS_PA_SEL_MSB = 4;
  localparam logic [15:0] ANPS_PA_VALID_MASK = 16'he7ff;
  localparam logic [15:0] ANPS_PA_RESET = 16'h0080;
  localparam logic [4:0] ANPS_SEL_CSMA_CD = 5'h01;

  // ------------------------------------------------------------
  // expansion field positions
  // ------------------------------------------------------------
  localparam int ANPS_EX_MULTI_FAULT = 4;
  localparam int ANPS_EX_PARTNER_NP = 3;
  localparam int ANPS_EX_LOCAL_NP = 2;
  localparam int ANPS_EX_PAGE_RX = 1;
  localparam int ANPS_EX_PARTNER_AN = 0;
  localparam logic [15:0] ANPS_EX_RESET = 16'h0000;

  // ------------------------------------------------------------
  // setup field positions
  // ------------------------------------------------------------
  localparam int ANPS_SU_LED_PULSE = 11;
  localparam int ANPS_SU_FAST_TIMER = 10;
  localparam int ANPS_SU_LOOPBACK = 9;
  localparam int ANPS_SU_ABD_SEEN = 2;
  localparam int ANPS_SU_PDF_SEEN = 1;
  localparam int ANPS_SU_LSC_SEEN = 0;
  localparam logic [15:0] ANPS_SU_RESET = 16'h0000;
  localparam logic [15:0] ANPS_SU_RW_MASK = 16'h0e00;

  // ------------------------------------------------------------
  // serial management preamble need after reset
  // ------------------------------------------------------------
  localparam int ANPS_FIRST_PREAMBLE_BITS = 32;
endpackage : anps_pkg

// ### hw/anps_sync.sv
// two-stage synchroniser for a bundle of pin levels
// assumes inputs are asynchronous to clk
`timescale 1ns/1ps
module anps_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule : anps_sync

// ### hw/anps_regs.sv
// negotiation result and setup register bank
// assumes a management frame engine on clk presents one-cycle read and
// write strobes with a 5-bit register address; the negotiation engine
// reports events as one-cycle pulses on clk; link pulse pin is async.
//
// Function
// RL1: partner ability holds partner's received word, read-only to management
// RL2: with next pages, contents update after each new page received
// RL3: bit 15 shows next page flag, 0 base page, reset 0
// RL4: bit 14 shows partner acknowledge of local word, reset 0
// RL5: bit 13 shows partner remote fault, reset 0
// RL6: bit 10 shows partner pause support, reset 0
// RL7: bits 9, 8, 6 show four pair, fast full, slow full abilities
// RL8: bit 7 fast half duplex, reset 1, set by 100 parallel detect
// RL9: bit 5 slow half duplex, reset 0, set by 10 parallel detect
// RL10: bits 4..0 hold received selector, reset zero; csma/cd is 00001
// RL11: expansion bits 15..5 always read zero
// RL12: expansion bit 4 shows multiple link fault, reset 0
// RL13: expansion bit 3 shows partner next page capable, reset 0
// RL14: expansion bit 2 shows local next page ability, read-only, reset 0
// RL15: expansion bit 1 set on new page, cleared by partner reg read
// RL16: expansion bit 0 shows partner negotiation capable, reset 0
// RL17: setup bit 11 routes link pulses onto fourth led, rw, reset 0
// RL18: setup bit 10 speeds up negotiation timers, rw, reset 0
// RL19: setup bit 9 puts negotiation in loopback, rw, reset 0
// RL20: setup bits 2..0 latch ability detect, pdf, link check states
// RL21: reserved bits read zero; writes to read-only bits ignored
// RL22: management sends 32 preamble bits first after reset, idle between
`timescale 1ns/1ps
module anps_regs
  import anps_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // management register access
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_rd,
  input wire logic mgmt_wr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  // negotiation engine results
  input wire logic page_rx_pulse,
  input wire logic [15:0] page_word,
  input wire logic next_page_enabled,
  input wire logic par_detect_100_pulse,
  input wire logic par_detect_10_pulse,
  input wire logic multiple_link_fault,
  input wire logic partner_next_page_capable,
  input wire logic local_next_page_capable,
  input wire logic partner_negotiation_capable,
  input wire logic ability_detect_state,
  input wire logic parallel_fault_state,
  input wire logic link_check_state,
  // line side and led
  input wire logic link_pulse_pin,
  input wire logic fourth_led_output_normal,
  output logic fourth_led_output,
  // setup controls to the negotiation engine
  output logic led_link_pulse_select,
  output logic timer_speedup,
  output logic negotiation_loopback
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [15:0] partner_ability_reg;
  logic [15:0] partner_ability_next;
  logic [4:0] expansion_reg;
  logic [4:0] expansion_next;
  logic [2:0] setup_ctl_reg;
  logic [2:0] setup_ctl_next;
  logic [2:0] setup_flag_reg;
  logic [2:0] setup_flag_next;
  logic [15:0] mgmt_rdata_reg;
  logic [15:0] mgmt_rdata_next;
  logic mgmt_rvalid_reg;
  logic mgmt_rvalid_next;
  logic fourth_led_reg;
  logic fourth_led_next;
  logic page_seen_reg;
  logic page_seen_next;
  logic link_pulse_sync;

  // ------------------------------------------------------------
  // pin synchroniser
  // ------------------------------------------------------------
  anps_sync #(.W(1)) u_pulse_sync (
    .clk(clk),
    .rst(rst),
    .d(link_pulse_pin),
    .q(link_pulse_sync)
  );

  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction : hit

  function automatic logic [15:0] view_expansion(input logic [4:0] e);
    view_expansion = {11'h000, e}; // RL11
  endfunction : view_expansion

  function automatic logic [15:0] view_setup(input logic [2:0] c,
                                             input logic [2:0] f);
    view_setup = {4'h0, c, 6'h00, f}; // RL21
  endfunction : view_setup

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    partner_ability_next = partner_ability_reg;
    expansion_next = expansion_reg;
    setup_ctl_next = setup_ctl_reg;
    setup_flag_next = setup_flag_reg;
    mgmt_rdata_next = mgmt_rdata_reg;
    mgmt_rvalid_next = 1'b0;
    page_seen_next = page_seen_reg;

    // base page always loads; later pages only with next pages enabled
    if (page_rx_pulse && (!page_seen_reg || next_page_enabled)) begin
      partner_ability_next = page_word & ANPS_PA_VALID_MASK; // RL1 RL2 RL21
      page_seen_next = 1'b1;
    end
    // parallel detection forces the matching half-duplex ability
    if (par_detect_100_pulse) begin
      partner_ability_next[ANPS_PA_FAST_HD] = 1'b1; // RL8
    end
    if (par_detect_10_pulse) begin
      partner_ability_next[ANPS_PA_SLOW_HD] = 1'b1; // RL9
    end

    expansion_next[ANPS_EX_MULTI_FAULT] = multiple_link_fault; // RL12
    expansion_next[ANPS_EX_PARTNER_NP] = partner_next_page_capable; // RL13
    expansion_next[ANPS_EX_LOCAL_NP] = local_next_page_capable; // RL14
    expansion_next[ANPS_EX_PARTNER_AN] = partner_negotiation_capable; // RL16

    // read clears page flag, but a page arriving same cycle wins
    if (mgmt_rd && hit(mgmt_addr, ANPS_ADDR_PARTNER_ABILITY)) begin
      expansion_next[ANPS_EX_PAGE_RX] = 1'b0; // RL15
    end
    if (page_rx_pulse) begin
      expansion_next[ANPS_EX_PAGE_RX] = 1'b1; // RL15
    end

    // sticky state flags, cleared only by reset
    if (ability_detect_state) begin
      setup_flag_next[ANPS_SU_ABD_SEEN] = 1'b1; // RL20
    end
    if (parallel_fault_state) begin
      setup_flag_next[ANPS_SU_PDF_SEEN] = 1'b1; // RL20
    end
    if (link_check_state) begin
      setup_flag_next[ANPS_SU_LSC_SEEN] = 1'b1; // RL20
    end

    // only the three control bits take writes
    if (mgmt_wr && hit(mgmt_addr, ANPS_ADDR_NEGOTIATION_SETUP)) begin
      setup_ctl_next = mgmt_wdata[ANPS_SU_LED_PULSE:ANPS_SU_LOOPBACK]; // RL21
    end

    if (mgmt_rd) begin
      mgmt_rvalid_next = 1'b1;
      case (mgmt_addr)
        ANPS_ADDR_PARTNER_ABILITY: begin
          mgmt_rdata_next = partner_ability_reg; // RL1
        end
        ANPS_ADDR_NEGOTIATION_EXPANSION: begin
          mgmt_rdata_next = view_expansion(expansion_reg);
        end
        ANPS_ADDR_NEGOTIATION_SETUP: begin
          mgmt_rdata_next = view_setup(setup_ctl_reg, setup_flag_reg);
        end
        default: begin
          mgmt_rdata_next = 16'h0000;
        end
      endcase
    end

    // fourth_led_output shows link pulses when selected
    if (setup_ctl_reg[2]) begin
      fourth_led_next = link_pulse_sync; // RL17
    end else begin
      fourth_led_next = fourth_led_output_normal;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      partner_ability_reg <= ANPS_PA_RESET; // RL3 RL4 RL5 RL6 RL7 RL10
      expansion_reg <= ANPS_EX_RESET[4:0];
      setup_ctl_reg <= ANPS_SU_RESET[ANPS_SU_LED_PULSE:ANPS_SU_LOOPBACK];
      setup_flag_reg <= ANPS_SU_RESET[ANPS_SU_ABD_SEEN:0];
      mgmt_rdata_reg <= 16'h0000;
      mgmt_rvalid_reg <= 1'b0;
      fourth_led_reg <= 1'b0;
      page_seen_reg <= 1'b0;
    end else begin
      partner_ability_reg <= partner_ability_next;
      expansion_reg <= expansion_next;
      setup_ctl_reg <= setup_ctl_next;
      setup_flag_reg <= setup_flag_next;
      mgmt_rdata_reg <= mgmt_rdata_next;
      mgmt_rvalid_reg <= mgmt_rvalid_next;
      fourth_led_reg <= fourth_led_next;
      page_seen_reg <= page_seen_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign mgmt_rdata = mgmt_rdata_reg;
  assign mgmt_rvalid = mgmt_rvalid_reg;
  assign fourth_led_output = fourth_led_reg;
  assign led_link_pulse_select = setup_ctl_reg[2]; // RL17
  assign timer_speedup = setup_ctl_reg[1]; // RL18
  assign negotiation_loopback = setup_ctl_reg[0]; // RL19
endmodule : anps_regs

// ### verification/anps_regs_sva.sv
// checker on the register bank ports
// assumes one clock domain and a sync active high reset
`timescale 1ns/1ps
module anps_regs_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // management
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_rd,
  input wire logic mgmt_wr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid,
  // led and controls
  input wire logic fourth_led_output_normal,
  input wire logic fourth_led_output,
  input wire logic led_link_pulse_select,
  input wire logic timer_speedup,
  input wire logic negotiation_loopback
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // steps of an access
  // ----------------------------------------
  sequence s_rd(a); mgmt_rd && mgmt_addr == a; endsequence
  sequence s_wr(a); mgmt_wr && mgmt_addr == a; endsequence
  // a write not overtaken by a second write to the same register
  sequence s_wr_alone(a);
    s_wr(a) ##1 !(mgmt_wr && mgmt_addr == a);
  endsequence
  sequence s_led_plain;
    !led_link_pulse_select [*3] ##0 $stable(fourth_led_output_normal);
  endsequence
  a_read_answer: assert property (mgmt_rd |=> mgmt_rvalid)
    else $error("read not answered");
  a_stray_valid: assert property (!mgmt_rd |=> !mgmt_rvalid)
    else $error("stray rvalid");
  a_partner_gap_zero: assert property (
    s_rd(5'h05) |=> mgmt_rdata[12:11] == 2'h0)
    else $error("partner gap set");
  a_expansion_top_zero: assert property (
    s_rd(5'h06) |=> mgmt_rdata[15:5] == 11'h000)
    else $error("expansion top set");
  a_setup_gaps_zero: assert property (
    s_rd(5'h10) |=> mgmt_rdata[15:12] == 4'h0 && mgmt_rdata[8:3] == 6'h00)
    else $error("setup gap set");
  a_unmapped_zero: assert property (
    mgmt_rd && !(mgmt_addr inside {5'h05, 5'h06, 5'h10})
    |=> mgmt_rdata == 16'h0000)
    else $error("unmapped read not zero");
  // sequence ends one edge after the write, so look two edges on
  a_setup_write_ctrl: assert property (
    s_wr_alone(5'h10) |=> {led_link_pulse_select, timer_speedup,
    negotiation_loopback} == $past(mgmt_wdata[11:9], 2))
    else $error("controls differ from write");
  a_led_normal: assert property (
    s_led_plain |-> fourth_led_output == fourth_led_output_normal)
    else $error("led not normal");
endmodule : anps_regs_chk

bind anps_regs anps_regs_chk u_chk (.clk, .rst, .mgmt_addr, .mgmt_rd,
  .mgmt_wr, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid, .fourth_led_output_normal,
  .fourth_led_output, .led_link_pulse_select, .timer_speedup,
  .negotiation_loopback);

// ### verification/anps_mgmt_model.sv
// management station model driving the register strobes
// assumes strobes are taken on the rising edge of clk
`timescale 1ns/1ps
module anps_mgmt_model (
  // clock
  input wire logic clk,
  // register access
  output logic [4:0] mgmt_addr,
  output logic mgmt_rd,
  output logic mgmt_wr,
  output logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid
);
  initial begin
    mgmt_addr = 5'h00;
    mgmt_rd = 1'b0;
    mgmt_wr = 1'b0;
    mgmt_wdata = 16'h0000;
  end
  // ----------------------------------------
  // accesses, at least one idle edge between (two after a read)
  // ----------------------------------------
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    mgmt_addr <= a;
    mgmt_wdata <= d;
    mgmt_wr <= 1'b1;
    @(posedge clk);
    mgmt_wr <= 1'b0;
    mgmt_wdata <= ~d; // stale data must not look valid
    mgmt_addr <= ~a;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d,
                    output logic v);
    @(posedge clk);
    mgmt_addr <= a;
    mgmt_rd <= 1'b1;
    @(posedge clk);
    mgmt_rd <= 1'b0;
    mgmt_addr <= ~a;
    @(posedge clk);
    v = mgmt_rvalid;
    d = mgmt_rdata;
  endtask : rd
endmodule : anps_mgmt_model

// ### verification/anps_regs_tb_top.sv
// testbench for the negotiation register bank
// assumes the management model and the bound checker
`timescale 1ns/1ps
module anps_regs_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] mgmt_addr;
  logic mgmt_rd, mgmt_wr, mgmt_rvalid;
  logic [15:0] mgmt_wdata, mgmt_rdata;
  logic [15:0] page_word = 16'h0000;
  logic [2:0] pulses = 3'h0;
  logic [6:0] lv = 7'h00;
  logic next_page_enabled = 1'b0;
  logic link_pulse_pin = 1'b0;
  logic fourth_led_output_normal = 1'b0;
  logic fourth_led_output, led_link_pulse_select;
  logic timer_speedup, negotiation_loopback;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  anps_regs uut (.clk, .rst, .mgmt_addr, .mgmt_rd, .mgmt_wr, .mgmt_wdata,
    .mgmt_rdata, .mgmt_rvalid, .page_rx_pulse(pulses[2]), .page_word,
    .next_page_enabled, .par_detect_100_pulse(pulses[1]),
    .par_detect_10_pulse(pulses[0]), .multiple_link_fault(lv[6]),
    .partner_next_page_capable(lv[5]), .local_next_page_capable(lv[4]),
    .partner_negotiation_capable(lv[3]), .ability_detect_state(lv[2]),
    .parallel_fault_state(lv[1]), .link_check_state(lv[0]),
    .link_pulse_pin, .fourth_led_output_normal, .fourth_led_output,
    .led_link_pulse_select, .timer_speedup, .negotiation_loopback);
  anps_mgmt_model mdl (.clk, .mgmt_addr, .mgmt_rd, .mgmt_wr, .mgmt_wdata,
    .mgmt_rdata, .mgmt_rvalid);
  always #4 clk = ~clk;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      finish_test();
    end
  end
  task automatic cmp(input string n, input logic [16:0] e, s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic v;
    mdl.rd(a, d, v);
    cmp($sformatf("reg %h", a), {1'b1, e}, {v, d});
  endtask : rchk
  task automatic pul(input logic [2:0] m);
    @(posedge clk);
    pulses <= m;
    @(posedge clk);
    pulses <= 3'h0;
  endtask : pul
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rchk(5'h05, 16'h0080);
    rchk(5'h06, 16'h0000);
    rchk(5'h10, 16'h0000);
    rchk(5'h1f, 16'h0000);
    mdl.wr(5'h05, 16'hffff);
    mdl.wr(5'h06, 16'hffff);
    mdl.wr(5'h10, 16'hffff);
    rchk(5'h05, 16'h0080);
    rchk(5'h06, 16'h0000);
    rchk(5'h10, 16'h0e00);
    cmp("ctrl", 17'h7, {led_link_pulse_select, timer_speedup,
      negotiation_loopback});
    link_pulse_pin <= 1'b1;
    repeat (4) @(posedge clk);
    cmp("led", 17'h1, fourth_led_output);
    link_pulse_pin <= 1'b0;
    fourth_led_output_normal <= 1'b1;
    mdl.wr(5'h10, 16'h0000);
    repeat (4) @(posedge clk);
    cmp("led", 17'h1, fourth_led_output);
    page_word <= 16'hffff;
    pul(3'h4);
    rchk(5'h06, 16'h0002);
    rchk(5'h05, 16'he7ff);
    rchk(5'h06, 16'h0000);
    page_word <= 16'h0001;
    pul(3'h4);
    rchk(5'h05, 16'he7ff);
    next_page_enabled <= 1'b1;
    pul(3'h4);
    rchk(5'h05, 16'h0001);
    pul(3'h2);
    rchk(5'h05, 16'h0081);
    pul(3'h1);
    rchk(5'h05, 16'h00a1);
    lv <= 7'h7f;
    @(posedge clk);
    lv <= 7'h78;
    rchk(5'h06, 16'h001d);
    rchk(5'h10, 16'h0007);
    lv <= 7'h00;
    rchk(5'h06, 16'h0000);
    rchk(5'h10, 16'h0007);
    finish_test();
  end
endmodule : anps_regs_tb_top
